/* File: pkg/grc_pkg.sv */
// grc_pkg: register map, field positions and carrier types for the
// global command low-bits register bank.
// assumes one clock domain and a 32-bit AXI4-Lite register bus.
package grc_pkg;

  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned STRB_W = 4;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CMD  = 12'h018;
  localparam logic [ADDR_W-1:0] OFS_STS  = 12'h01c;
  localparam logic [ADDR_W-1:0] OFS_IRTA = 12'h020;

  // command and status field positions (same bit in both registers)
  localparam int unsigned BIT_QINV   = 26;
  localparam int unsigned BIT_REMAP  = 25;
  localparam int unsigned BIT_SETPTR = 24;
  localparam int unsigned BIT_COMPAT = 23;

  // byte lane that carries each command bit
  localparam int unsigned LANE_HI     = 3;
  localparam int unsigned LANE_COMPAT = 2;

  localparam logic [DATA_W-1:0] ZERO_WORD  = 32'h0000_0000;
  localparam logic [DATA_W-1:0] IRTA_RESET = 32'h0000_0000;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // one register write as seen by the bank
  typedef struct packed {
    logic              en;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [STRB_W-1:0] strb;
  } grc_wr_s;

  // one register read request as seen by the bank
  typedef struct packed {
    logic              en;
    logic [ADDR_W-1:0] addr;
  } grc_rd_s;

  typedef enum logic {
    SEQ_IDLE = 1'b0,
    SEQ_WAIT = 1'b1
  } grc_seq_e;

  typedef enum logic [1:0] {
    WB_IDLE = 2'b00,
    WB_WAIT = 2'b01,
    WB_DONE = 2'b10
  } grc_wb_e;

endpackage

/* File: logic/grc_axil_slave.sv */
// grc_axil_slave: AXI4-Lite slave front end, one write and one read at a time.
// assumes the bank answers decode and read data combinationally.
`timescale 1ns/100ps
`default_nettype none

module grc_axil_slave
  import grc_pkg::*;
(
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic [ADDR_W-1:0]     s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [DATA_W-1:0]     s_axi_wdata,
  input  wire logic [STRB_W-1:0]     s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [ADDR_W-1:0]     s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [DATA_W-1:0]          s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  output grc_pkg::grc_wr_s           wr,
  input  wire logic                  wr_ok,
  output grc_pkg::grc_rd_s           rd,
  input  wire logic [DATA_W-1:0]     rd_data,
  input  wire logic                  rd_ok
);

  logic [ADDR_W-1:0] awaddr_q;
  logic [DATA_W-1:0] wdata_q;
  logic [STRB_W-1:0] wstrb_q;
  logic              wr_fire;

  // a write fires once both halves are held and no response is pending
  assign wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign wr      = '{en: wr_fire, addr: awaddr_q, data: wdata_q, strb: wstrb_q};
  assign rd      = '{en: s_axi_arvalid && s_axi_arready, addr: s_axi_araddr};

  // address and data are taken in either order; ready drops while held
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      awaddr_q      <= '0;
      wdata_q       <= '0;
      wstrb_q       <= '0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        s_axi_awready <= 1'b0;
        awaddr_q      <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        s_axi_wready <= 1'b0;
        wdata_q      <= s_axi_wdata;
        wstrb_q      <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // write response one cycle after the write fires
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready)
    begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // read data captured at the address handshake; no new address till rready
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= ZERO_WORD;
      s_axi_rresp   <= RESP_OKAY;
    end
    else if (rd.en)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_data;
      s_axi_rresp   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
    end
  end

endmodule

`default_nettype wire

/* File: logic/grc_remap_seq.sv */
// grc_remap_seq: moves the interrupt remap on/off state toward the target
// at a safe moment, and flags a cache flush when switching off.
// assumes boundary and in-flight indications come from the same clock.
`timescale 1ns/100ps
`default_nettype none

module grc_remap_seq
  import grc_pkg::*;
(
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic want_on,
  input  wire logic txn_boundary,
  input  wire logic irq_inflight,
  input  wire logic flush_on_off,
  output logic      on_q,
  output logic      cache_inval_q
);

  grc_seq_e state_q;
  logic     safe;

  assign safe = txn_boundary && (!want_on || !irq_inflight);

  // target may change while waiting; a reversal simply cancels the wait
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_q       <= SEQ_IDLE;
      on_q          <= 1'b0;
      cache_inval_q <= 1'b0;
    end
    else
    begin
      cache_inval_q <= 1'b0;
      unique case (state_q)
        SEQ_IDLE:
        begin
          if (want_on != on_q)
            state_q <= SEQ_WAIT;
        end
        SEQ_WAIT:
        begin
          if (want_on == on_q)
            state_q <= SEQ_IDLE;
          else if (safe)
          begin
            on_q    <= want_on;
            state_q <= SEQ_IDLE;
            cache_inval_q <= !want_on && flush_on_off;
          end
        end
      endcase
    end
  end

endmodule

`default_nettype wire

/* File: logic/grc_top.sv */
// grc_top: global command low-bits register bank with its status bits,
// remap table pointer latch and implicit write buffer flush sequencing.
// assumes all side inputs are driven by logic on aclk.
`timescale 1ns/100ps
`default_nettype none

module grc_top
  import grc_pkg::*;
#(
  parameter bit SUP_QINVAL   = 1'b1,
  parameter bit SUP_REMAP    = 1'b1,
  parameter bit SUP_ENH_PTR  = 1'b1,
  parameter bit WBF_REQUIRED = 1'b1
)
(
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire logic [grc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [grc_pkg::DATA_W-1:0] s_axi_wdata,
  input  wire logic [grc_pkg::STRB_W-1:0] s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [grc_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [grc_pkg::DATA_W-1:0]     s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  input  wire logic                      irq_inflight,
  input  wire logic                      txn_boundary,
  input  wire logic                      ext_int_mode,
  input  wire logic                      inval_req,
  input  wire logic                      wb_flush_done,
  output logic                           remap_enabled,
  output logic                           qinval_enabled,
  output logic                           compat_pass,
  output logic                           compat_block,
  output logic [grc_pkg::DATA_W-1:0]     remap_table_ptr,
  output logic                           remap_cache_inval,
  output logic                           wb_flush_req,
  output logic                           inval_go
);

  import grc_pkg::*;

  grc_wr_s           wr;
  grc_rd_s           rd;
  logic              wr_ok;
  logic              rd_ok;
  logic [DATA_W-1:0] rd_data;

  logic [DATA_W-1:0] irta_q;
  logic              qinv_tgt_q;
  logic              qinv_stat_q;
  logic              remap_tgt_q;
  logic              remap_on;
  logic              compat_tgt_q;
  logic              compat_stat_q;
  logic              ptr_stat_q;
  logic              latch_q;
  logic              cmd_wr;
  logic              lane_hi;
  logic              lane_compat;
  grc_wb_e           wb_q;

  // merge written byte lanes into an old register value
  function automatic logic [DATA_W-1:0] merge_strb(
    input logic [DATA_W-1:0] old_v,
    input logic [DATA_W-1:0] new_v,
    input logic [STRB_W-1:0] strb
  );
    logic [DATA_W-1:0] res;
    res = old_v;
    for (int i = 0; i < STRB_W; i++)
    begin
      if (strb[i])
        res[i*8 +: 8] = new_v[i*8 +: 8];
    end
    return res;
  endfunction

  // true for any address the bank answers
  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    return (a == OFS_CMD) || (a == OFS_STS) || (a == OFS_IRTA);
  endfunction

  grc_axil_slave u_bus (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .wr            (wr),
    .wr_ok         (wr_ok),
    .rd            (rd),
    .rd_data       (rd_data),
    .rd_ok         (rd_ok)
  );

  // status is read-only, so a write to it is refused with an error
  assign wr_ok    = (wr.addr == OFS_CMD) || (wr.addr == OFS_IRTA);
  assign rd_ok    = is_mapped(rd.addr);
  assign cmd_wr   = wr.en && (wr.addr == OFS_CMD);
  assign lane_hi  = wr.strb[LANE_HI];
  assign lane_compat = wr.strb[LANE_COMPAT];

  // read mux
  always_comb
  begin
    rd_data = ZERO_WORD;
    if (rd.addr == OFS_STS)
    begin
      rd_data[BIT_QINV]   = qinv_stat_q;
      rd_data[BIT_REMAP]  = remap_on;
      rd_data[BIT_SETPTR] = ptr_stat_q;
      rd_data[BIT_COMPAT] = compat_stat_q;
    end
    else if (rd.addr == OFS_IRTA)
      rd_data = irta_q;
    else
      rd_data = ZERO_WORD;
  end

  // table address register, written by software with byte enables
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irta_q <= IRTA_RESET;
    else if (wr.en && (wr.addr == OFS_IRTA))
      irta_q <= merge_strb(irta_q, wr.data, wr.strb);
  end

  // command targets; bits 22..0 and unsupported features are dropped
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      qinv_tgt_q   <= 1'b0;
      remap_tgt_q  <= 1'b0;
      compat_tgt_q <= 1'b0;
    end
    else if (cmd_wr)
    begin
      if (lane_hi && SUP_QINVAL)
        qinv_tgt_q <= wr.data[BIT_QINV];
      if (lane_hi && SUP_REMAP)
        remap_tgt_q <= wr.data[BIT_REMAP];
      if (lane_compat && SUP_REMAP)
        compat_tgt_q <= wr.data[BIT_COMPAT];
    end
  end

  // status follows the request one cycle later
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      qinv_stat_q   <= 1'b0;
      compat_stat_q <= 1'b0;
    end
    else
    begin
      qinv_stat_q   <= qinv_tgt_q;
      compat_stat_q <= compat_tgt_q;
    end
  end

  // remap on waits for a boundary and a drained queue; off waits for a boundary only
  grc_remap_seq u_seq (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .want_on       (remap_tgt_q),
    .txn_boundary  (txn_boundary),
    .irq_inflight  (irq_inflight),
    .flush_on_off  (SUP_ENH_PTR),
    .on_q          (remap_on),
    .cache_inval_q (remap_cache_inval)
  );

  // set-pointer: clear status at the write, latch and set one cycle later
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      latch_q         <= 1'b0;
      ptr_stat_q      <= 1'b0;
      remap_table_ptr <= IRTA_RESET;
    end
    else
    begin
      latch_q <= 1'b0;
      if (cmd_wr && lane_hi && SUP_REMAP && wr.data[BIT_SETPTR])
      begin
        latch_q <= 1'b1;
        ptr_stat_q <= 1'b0;
      end
      // set wins: a completing latch is not undone by a fresh command edge
      if (latch_q)
      begin
        remap_table_ptr <= irta_q;
        ptr_stat_q <= 1'b1;
      end
    end
  end

  // software orders pointer before enable; no hardware interlock
  // side outputs, registered so every output leaves a flip-flop
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      remap_enabled  <= 1'b0;
      qinval_enabled <= 1'b0;
      compat_pass    <= 1'b0;
      compat_block   <= 1'b0;
    end
    else
    begin
      remap_enabled  <= remap_on;
      qinval_enabled <= qinv_stat_q;
      compat_pass    <= remap_on && !ext_int_mode && compat_stat_q;
      compat_block   <= remap_on && !ext_int_mode && !compat_stat_q;
    end
  end

  // flush before invalidation
  // the requester holds inval_req until inval_go and drops it right after
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wb_q         <= WB_IDLE;
      wb_flush_req <= 1'b0;
      inval_go     <= 1'b0;
    end
    else
    begin
      wb_flush_req <= 1'b0;
      inval_go     <= 1'b0;
      unique case (wb_q)
        WB_IDLE:
        begin
          if (inval_req && WBF_REQUIRED)
          begin
            wb_flush_req <= 1'b1;
            wb_q         <= WB_WAIT;
          end
          else if (inval_req)
          begin
            inval_go <= 1'b1;
            wb_q     <= WB_DONE;
          end
        end
        WB_WAIT:
        begin
          if (wb_flush_done)
          begin
            inval_go <= 1'b1;
            wb_q     <= WB_DONE;
          end
        end
        WB_DONE:
        begin
          wb_q <= WB_IDLE;
        end
        default:
        begin
          wb_q <= WB_IDLE;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

/* File: test/grc_top_asserts.sv */
// grc_top_asserts: port-level checks of the command bank, bound into grc_top.
// assumes one clock, synchronous active-low reset, writes one at a time.
`timescale 1ns/100ps
`default_nettype none

module grc_top_asserts
(
  input wire logic                         aclk,
  input wire logic                         aresetn,
  input wire logic [grc_pkg::ADDR_W-1:0]   s_axi_awaddr,
  input wire logic                         s_axi_awvalid,
  input wire logic                         s_axi_awready,
  input wire logic [grc_pkg::DATA_W-1:0]   s_axi_wdata,
  input wire logic [grc_pkg::STRB_W-1:0]   s_axi_wstrb,
  input wire logic                         s_axi_wvalid,
  input wire logic                         s_axi_wready,
  input wire logic [1:0]                   s_axi_bresp,
  input wire logic                         s_axi_bvalid,
  input wire logic                         irq_inflight,
  input wire logic                         txn_boundary,
  input wire logic                         ext_int_mode,
  input wire logic                         inval_req,
  input wire logic                         remap_enabled,
  input wire logic                         qinval_enabled,
  input wire logic                         compat_pass,
  input wire logic                         compat_block,
  input wire logic [grc_pkg::DATA_W-1:0]   remap_table_ptr,
  input wire logic                         remap_cache_inval,
  input wire logic                         wb_flush_req,
  input wire logic                         inval_go
);
  import grc_pkg::*;

  logic aw_cmd_q, aw_sts_q, qinv_lane_q, qinv_val_q, setptr_q, flushed_q;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // remember what the write carried; left unreset, unknown until first write
  always_ff @(posedge aclk)
  begin
    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_cmd_q <= (s_axi_awaddr == OFS_CMD);
      aw_sts_q <= (s_axi_awaddr == OFS_STS);
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      qinv_lane_q <= s_axi_wstrb[LANE_HI];
      qinv_val_q  <= s_axi_wdata[BIT_QINV];
      setptr_q    <= s_axi_wdata[BIT_SETPTR] && s_axi_wstrb[LANE_HI];
    end
  end

  // a flush request must stand between invalidation and its go
  always_ff @(posedge aclk)
  begin
    if (!aresetn || inval_go)
      flushed_q <= 1'b0;
    else if (wb_flush_req)
      flushed_q <= 1'b1;
  end

  sequence flush_pulse;
    wb_flush_req ##1 !wb_flush_req;
  endsequence

  sequence remap_falls;
    remap_enabled ##1 !remap_enabled;
  endsequence

  AST_QINV_TRACK: assert property ($rose(s_axi_bvalid) && aw_cmd_q && qinv_lane_q
    && s_axi_bresp == RESP_OKAY |-> ##2 qinval_enabled == $past(qinv_val_q, 2))
    else $error("queued invalidation state does not follow the command");
  AST_PTR_ONLY_CMD: assert property ($changed(remap_table_ptr) |->
    $past(s_axi_bvalid) && aw_cmd_q && setptr_q)
    else $error("table pointer moved without a set-pointer command");
  AST_STS_WR_ERR: assert property ($rose(s_axi_bvalid) && aw_sts_q |->
    s_axi_bresp == RESP_SLVERR)
    else $error("write to status register not refused");
  AST_REMAP_EDGE: assert property ($changed(remap_enabled) |->
    $past(txn_boundary, 2))
    else $error("remap state changed away from a transaction boundary");
  AST_REMAP_DRAIN: assert property ($rose(remap_enabled) |->
    !$past(irq_inflight, 2))
    else $error("remap enabled with interrupts still in flight");
  AST_CACHE_INVAL: assert property (remap_cache_inval |-> remap_falls)
    else $error("cache invalidation not tied to remap turning off");
  AST_COMPAT_EXCL: assert property (!(compat_pass && compat_block))
    else $error("compat pass and block both high");
  AST_COMPAT_GATE: assert property ((compat_pass || compat_block) |->
    remap_enabled && !$past(ext_int_mode))
    else $error("compat setting active outside its mode");
  AST_FLUSH_FIRST: assert property ($rose(inval_req) |-> ##[1:2] flush_pulse)
    else $error("no write buffer flush pulse after invalidation request");
  AST_GO_AFTER_FL: assert property (inval_go |-> flushed_q)
    else $error("invalidation released without a flush");
endmodule

bind grc_top grc_top_asserts chk_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .irq_inflight, .txn_boundary, .ext_int_mode,
  .inval_req, .remap_enabled, .qinval_enabled, .compat_pass, .compat_block,
  .remap_table_ptr, .remap_cache_inval, .wb_flush_req, .inval_go);
`default_nettype wire

/* File: test/grc_top_bench.sv */
// grc_top_bench: directed scenarios for the command bank over AXI4-Lite.
// assumes grc_top with default feature parameters and the bound checker.
`timescale 1ns/100ps
`default_nettype none

module grc_top_bench;
  import grc_pkg::*;

  logic                aclk = 1'b0, aresetn = 1'b0;
  logic [ADDR_W-1:0]   s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [DATA_W-1:0]   s_axi_wdata = 32'h0, s_axi_rdata, remap_table_ptr, rdv;
  logic [STRB_W-1:0]   s_axi_wstrb = 4'h0;
  logic                s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic                s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic                irq_inflight = 1'b0, txn_boundary = 1'b0, ext_int_mode = 1'b0;
  logic                inval_req = 1'b0, wb_flush_done = 1'b0;
  logic                s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic                s_axi_rvalid, remap_enabled, qinval_enabled, compat_pass;
  logic                compat_block, remap_cache_inval, wb_flush_req, inval_go;
  logic [1:0]          s_axi_bresp, s_axi_rresp, rsp;
  int                  fail_count = 0, checks = 0, cyc = 0, n, m;

  grc_top dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq_inflight,
    .txn_boundary, .ext_int_mode, .inval_req, .wb_flush_done, .remap_enabled,
    .qinval_enabled, .compat_pass, .compat_block, .remap_table_ptr,
    .remap_cache_inval, .wb_flush_req, .inval_go);

  // 50 MHz clock
  always #10 aclk = ~aclk;

  // hang guard, far above the roughly 150 cycles the run needs
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      fail_count++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
    checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic idle(input int c);
    repeat (c) @(posedge aclk);
  endtask

  // write: both halves offered together, each dropped once taken
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                    input logic [STRB_W-1:0] s);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    @(posedge aclk);
    while (s_axi_bvalid !== 1'b1)
    begin
      if (s_axi_awready === 1'b1)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1)
        s_axi_wvalid <= 1'b0;
      @(posedge aclk);
    end
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    @(posedge aclk);
    while (s_axi_rvalid !== 1'b1)
    begin
      if (s_axi_arready === 1'b1)
        s_axi_arvalid <= 1'b0;
      @(posedge aclk);
    end
    rdv = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask

  // reset values, refused accesses
  task automatic t_reset();
    rd(OFS_STS);
    chk("status at reset", ZERO_WORD, rdv);
    rd(OFS_IRTA);
    chk("table address at reset", IRTA_RESET, rdv);
    chk("pointer at reset", ZERO_WORD, remap_table_ptr);
    wr(OFS_STS, 32'hffff_ffff, 4'hf);
    chk("status write resp", {30'h0, RESP_SLVERR}, {30'h0, rsp});
    rd(OFS_STS);
    chk("status after write", ZERO_WORD, rdv);
    rd(12'h100);
    chk("unmapped read resp", {30'h0, RESP_SLVERR}, {30'h0, rsp});
  endtask

  // queued invalidation on and off, reserved bits and wrong lane ignored
  task automatic t_qie();
    wr(OFS_CMD, (32'h1 << BIT_QINV) | 32'h007f_ffff, 4'hf);
    rd(OFS_STS);
    chk("qi status on", 32'h0400_0000, rdv);
    chk("qi port on", 32'h1, {31'h0, qinval_enabled});
    wr(OFS_CMD, ZERO_WORD, 4'h4);
    rd(OFS_STS);
    chk("qi kept by lane", 32'h0400_0000, rdv);
    wr(OFS_CMD, ZERO_WORD, 4'h8);
    rd(OFS_STS);
    chk("qi status off", ZERO_WORD, rdv);
    chk("qi port off", 32'h0, {31'h0, qinval_enabled});
  endtask

  // pointer latch, zero write without effect, byte merge, reload
  task automatic t_ptr();
    wr(OFS_IRTA, 32'h1234_5000, 4'hf);
    wr(OFS_CMD, 32'h1 << BIT_SETPTR, 4'h8);
    rd(OFS_STS);
    chk("pointer status", 32'h1 << BIT_SETPTR, rdv);
    chk("pointer loaded", 32'h1234_5000, remap_table_ptr);
    wr(OFS_IRTA, 32'h0abc_d000, 4'h3);
    wr(OFS_CMD, ZERO_WORD, 4'hf);
    chk("pointer after zero", 32'h1234_5000, remap_table_ptr);
    wr(OFS_CMD, 32'h1 << BIT_SETPTR, 4'h8);
    rd(OFS_STS);
    chk("pointer status again", 32'h1 << BIT_SETPTR, rdv);
    chk("pointer reloaded", 32'h1234_d000, remap_table_ptr);
  endtask

  // enable waits for drain and boundary; pointer was set first
  task automatic t_remap_on();
    irq_inflight <= 1'b1;
    txn_boundary <= 1'b1;
    wr(OFS_CMD, 32'h1 << BIT_REMAP, 4'h8);
    idle(4);
    rd(OFS_STS);
    chk("remap held by inflight", 32'h0, {31'h0, rdv[BIT_REMAP]});
    irq_inflight <= 1'b0;
    txn_boundary <= 1'b0;
    idle(4);
    rd(OFS_STS);
    chk("remap held off boundary", 32'h0, {31'h0, rdv[BIT_REMAP]});
    txn_boundary <= 1'b1;
    idle(4);
    rd(OFS_STS);
    chk("remap status on", 32'h1, {31'h0, rdv[BIT_REMAP]});
    chk("remap port on", 32'h1, {31'h0, remap_enabled});
  endtask

  // compat pass, block, and masked by extended mode
  task automatic t_cfi();
    wr(OFS_CMD, (32'h1 << BIT_REMAP) | (32'h1 << BIT_COMPAT), 4'hc);
    rd(OFS_STS);
    chk("compat status set", 32'h1, {31'h0, rdv[BIT_COMPAT]});
    chk("compat pass", 32'h1, {31'h0, compat_pass});
    wr(OFS_CMD, 32'h1 << BIT_REMAP, 4'hc);
    rd(OFS_STS);
    chk("compat status clear", 32'h0, {31'h0, rdv[BIT_COMPAT]});
    chk("compat block", 32'h1, {31'h0, compat_block});
    ext_int_mode <= 1'b1;
    idle(3);
    chk("compat masked", 32'h0, {30'h0, compat_pass, compat_block});
    ext_int_mode <= 1'b0;
    idle(3);
    chk("compat back", 32'h1, {31'h0, compat_block});
  endtask

  // disable waits for a boundary and flushes remap caches once
  task automatic t_remap_off();
    txn_boundary <= 1'b0;
    wr(OFS_CMD, ZERO_WORD, 4'h8);
    idle(3);
    rd(OFS_STS);
    chk("remap kept off boundary", 32'h1, {31'h0, rdv[BIT_REMAP]});
    txn_boundary <= 1'b1;
    n = 0;
    repeat (8)
    begin
      @(posedge aclk);
      if (remap_cache_inval === 1'b1)
        n++;
    end
    chk("cache inval pulses", 32'h1, n);
    rd(OFS_STS);
    chk("remap status off", 32'h0, {31'h0, rdv[BIT_REMAP]});
    chk("compat off with remap", 32'h0, {31'h0, compat_block});
  endtask

  // invalidation gated behind an implicit buffer flush
  task automatic t_inval();
    inval_req <= 1'b1;
    n = 0;
    m = 0;
    repeat (6)
    begin
      @(posedge aclk);
      if (wb_flush_req === 1'b1)
        n++;
      if (inval_go === 1'b1)
        m++;
    end
    chk("flush pulses", 32'h1, n);
    chk("go before flush done", 32'h0, m);
    wb_flush_done <= 1'b1;
    repeat (6)
    begin
      @(posedge aclk);
      if (inval_go === 1'b1 && m == 0)
      begin
        m++;
        inval_req <= 1'b0;
      end
    end
    wb_flush_done <= 1'b0;
    chk("go after flush done", 32'h1, m);
  endtask

  initial
  begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_qie();
    t_ptr();
    t_remap_on();
    t_cfi();
    t_remap_off();
    t_inval();
    idle(4);
    end_of_test();
  end
endmodule
`default_nettype wire
